// ==== rtl/tsc_pkg.sv ====
// Purpose: shared constants for the touch slot counter control block
// Assumes: AHB-Lite register access, one 32-bit word per register, data in low byte
// Notes:   offsets are byte addresses inside a 4 KiB window
package tsc_pkg;

   // widths
   localparam int unsigned ADDR_W      = 12;
   localparam int unsigned REG_W       = 8;
   localparam int unsigned PRESCALE_W  = 5;
   localparam int unsigned SLOT_W      = 8;
   localparam int unsigned CNT_W       = 16;
   localparam int unsigned REFCAP_W    = 10;
   localparam int unsigned DIV_W       = 3;
   localparam int unsigned IRQ_W       = 3;
   localparam int unsigned MAX_MODULES = 4;

   // common register offsets
   localparam logic [ADDR_W-1:0] OFS_SLOT_PRELOAD = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_CTRL_ZERO    = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_CTRL_ONE     = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_FUNC_LOW     = 12'h00c;
   localparam logic [ADDR_W-1:0] OFS_FUNC_HIGH    = 12'h010;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS   = 12'h014;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK     = 12'h018;

   // per-module register block
   localparam logic [ADDR_W-1:0] MOD_BASE         = 12'h020;
   localparam logic [ADDR_W-1:0] MOD_STRIDE       = 12'h020;
   localparam logic [ADDR_W-1:0] MOFS_SENSE_LOW   = 12'h000;
   localparam logic [ADDR_W-1:0] MOFS_SENSE_HIGH  = 12'h004;
   localparam logic [ADDR_W-1:0] MOFS_REFCAP_LOW  = 12'h008;
   localparam logic [ADDR_W-1:0] MOFS_REFCAP_HIGH = 12'h00c;
   localparam logic [ADDR_W-1:0] MOFS_CTRL_ZERO   = 12'h010;
   localparam logic [ADDR_W-1:0] MOFS_CTRL_ONE    = 12'h014;

   // touch_control_zero fields
   localparam int unsigned C0_SLOT_OVF  = 6;
   localparam int unsigned C0_START     = 5;
   localparam int unsigned C0_SENSE_OVF = 4;
   localparam int unsigned C0_FUNC_OVF  = 3;
   localparam int unsigned C0_SHARED    = 2;
   localparam int unsigned C0_FSEL_LO   = 0;
   localparam logic [REG_W-1:0] C0_RW_MASK = 8'h27;

   // module_control_one fields
   localparam int unsigned MC1_SLOT_CLK = 7;
   localparam logic [REG_W-1:0] MC1_MASK = 8'hbf;

   // reset values and implemented bits
   localparam logic [REG_W-1:0] PRELOAD_RST   = 8'h00;
   localparam logic [REG_W-1:0] C0_RST        = 8'h00;
   localparam logic [1:0]       FREQ_SEL_RST  = 2'h3;
   localparam logic [REG_W-1:0] MOD_REG_RST   = 8'h00;

   // irq status bits
   localparam int unsigned IRQ_SLOT  = 0;
   localparam int unsigned IRQ_SENSE = 1;
   localparam int unsigned IRQ_FUNC  = 2;

   typedef enum logic [3:0] {
      BUS_IDLE    = 4'b0001,
      BUS_WRITE   = 4'b0010,
      BUS_RD_WAIT = 4'b0100,
      BUS_RD_DONE = 4'b1000
   } tsc_bus_e;

endpackage : tsc_pkg

// ==== rtl/tsc_module.sv ====
// Purpose: one touch module: unit prescaler, slot counter and sense counter
// Assumes: oscillator inputs synchronous to clk_i, slower than clk_i/2
// Notes:   counting edges of the oscillators, not clocking on them
`timescale 1ns/1ps
module tsc_module (
   // clock and reset
   input  wire logic                        clk_i,
   input  wire logic                        rst_b_i,
   // control
   input  wire logic                        clear_i,
   input  wire logic                        load_i,
   input  wire logic                        count_en_i,
   input  wire logic [tsc_pkg::SLOT_W-1:0]  preload_i,
   input  wire logic                        slot_clk_sel_i,
   input  wire logic                        sys_div4_en_i,
   // oscillators
   input  wire logic                        ref_osc_i,
   input  wire logic                        sense_osc_i,
   // results
   output logic                             slot_ovf_o,
   output logic                             sense_ovf_o,
   output logic [tsc_pkg::CNT_W-1:0]        sense_count_o
);
   import tsc_pkg::*;

   logic                  ref_prev;
   logic                  sense_prev;
   logic [PRESCALE_W-1:0] prescale;
   logic [SLOT_W-1:0]     slot_count;
   logic                  tick;
   logic                  unit_done;
   logic                  sense_inc;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ref_prev   <= 1'b0;
         sense_prev <= 1'b0;
      end else begin
         ref_prev   <= ref_osc_i;
         sense_prev <= sense_osc_i;
      end
   end

   assign tick = count_en_i & (slot_clk_sel_i ? sys_div4_en_i : (ref_osc_i & ~ref_prev));
   assign unit_done  = tick & (&prescale);
   assign slot_ovf_o = unit_done & (&slot_count);
   assign sense_inc  = count_en_i & sense_osc_i & ~sense_prev;
   assign sense_ovf_o = sense_inc & (&sense_count_o);

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prescale <= '0;
      end else if (clear_i) begin
         prescale <= '0;
      end else if (tick) begin
         prescale <= prescale + 1'b1;
      end
   end

   // slot counter kept when start drops
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         slot_count <= '0;
      end else if (load_i) begin
         slot_count <= preload_i;
      end else if (unit_done) begin
         slot_count <= slot_count + 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sense_count_o <= '0;
      end else if (clear_i) begin
         sense_count_o <= '0;
      end else if (sense_inc) begin
         sense_count_o <= sense_count_o + 1'b1;
      end
   end

endmodule : tsc_module

// ==== rtl/tsc_top.sv ====
// Purpose: touch slot counter control with AHB-Lite register access
// Assumes: oscillator and sense inputs synchronous to clk_i
// Notes:   reads take one wait state, writes none
// Operation
// - slot period is (256-preload) times 32 ticks
// - 5-bit prescaler advances slot counter each 32
// - slot overflow sets flag and touch irq
// - slot overflow stops oscillators and all counters
// - slot flag only cleared by writing zero
// - start low clears sense, function, prescale counters
// - start low leaves slot counter uncleared
// - start rising edge enables counters and oscillators
// - sense overflow sets flag, write zero clears
// - function overflow sets flag, write zero clears
// - shared select picks own or module 0 slot
// - function clock is fsys divided 1,2,4,8
// - oscillator frequency select, resets to code 3
// - function counter holds value after slot overflow
// - function count reads zero while start low
// - frequency register upper bits read zero
// - sense counter wraps on overflow, holds after slot overflow until start low
// - slot clock is reference oscillator or fsys/4
`timescale 1ns/1ps
module tsc_top #(
   parameter int unsigned NUM_MODULES = 2
) (
   // clock and reset
   input  wire logic                                       clk_i,
   input  wire logic                                       rst_b_i,
   // ahb-lite slave
   input  wire logic                                       hsel_i,
   input  wire logic [31:0]                                haddr_i,
   input  wire logic [1:0]                                 htrans_i,
   input  wire logic                                       hwrite_i,
   input  wire logic [2:0]                                 hsize_i,
   input  wire logic [31:0]                                hwdata_i,
   input  wire logic                                       hready_i,
   output logic                                            hreadyout_o,
   output logic                                            hresp_o,
   output logic [31:0]                                     hrdata_o,
   // oscillators, one per module
   input  wire logic [NUM_MODULES-1:0]                     ref_osc_i,
   input  wire logic [NUM_MODULES-1:0]                     sense_osc_i,
   output logic [NUM_MODULES-1:0]                          osc_run_o,
   output logic [1:0]                                      osc_freq_sel_o,
   // per-module analogue settings
   output logic [NUM_MODULES*tsc_pkg::REG_W-1:0]           module_ctrl_zero_o,
   output logic [NUM_MODULES*tsc_pkg::REG_W-1:0]           module_ctrl_one_o,
   output logic [NUM_MODULES*tsc_pkg::REFCAP_W-1:0]        module_refcap_o,
   // interrupt
   output logic                                            irq_o
);
   import tsc_pkg::*;

   if (NUM_MODULES < 1 || NUM_MODULES > MAX_MODULES) begin : g_bad_count
      $error("tsc_top: NUM_MODULES must be 1 to 4");
   end

   tsc_bus_e              bus_state;
   tsc_bus_e              next_bus_state;
   logic [ADDR_W-1:0]     addr_q;
   logic                  accept;
   logic                  wr_en;
   logic [REG_W-1:0]      wdata;
   logic [REG_W-1:0]      rd_mux;

   logic [REG_W-1:0]      slot_preload;
   logic                  start;
   logic                  start_prev;
   logic                  start_rise;
   logic                  shared_slot;
   logic [1:0]            func_clk_sel;
   logic [1:0]            freq_sel;
   logic                  slot_ovf_flag;
   logic                  sense_ovf_flag;
   logic                  func_ovf_flag;
   logic [IRQ_W-1:0]      irq_status;
   logic [IRQ_W-1:0]      irq_mask;
   logic [IRQ_W-1:0]      irq_event;

   logic                  run;
   logic                  global_ovf;
   logic [DIV_W-1:0]      div_cnt;
   logic                  func_en;
   logic                  div4_en;
   logic [CNT_W-1:0]      func_count;
   logic                  func_inc;
   logic                  func_ovf;
   logic                  sense_ovf_any;

   logic [NUM_MODULES-1:0] mod_done;
   logic [NUM_MODULES-1:0] mod_en;
   logic [NUM_MODULES-1:0] mod_slot_ovf;
   logic [NUM_MODULES-1:0] mod_sense_ovf;
   logic [CNT_W-1:0]       mod_sense [NUM_MODULES];
   logic [REFCAP_W-1:0]    mod_refcap [NUM_MODULES];
   logic [REG_W-1:0]       mod_ctrl0 [NUM_MODULES];
   logic [REG_W-1:0]       mod_ctrl1 [NUM_MODULES];
   logic [ADDR_W-1:0]      mofs [NUM_MODULES];
   // bus slave: a read waits one cycle so any write just before has landed
   assign accept      = hsel_i & hready_i & htrans_i[1];
   assign hreadyout_o = (bus_state != BUS_RD_WAIT);
   assign hresp_o     = 1'b0;
   assign wr_en       = (bus_state == BUS_WRITE);
   assign wdata       = hwdata_i[REG_W-1:0];

   always_comb begin
      next_bus_state = bus_state;
      unique case (bus_state)
         BUS_RD_WAIT: next_bus_state = BUS_RD_DONE;
         BUS_IDLE, BUS_WRITE, BUS_RD_DONE: begin
            if (accept) begin
               next_bus_state = hwrite_i ? BUS_WRITE : BUS_RD_WAIT;
            end else begin
               next_bus_state = BUS_IDLE;
            end
         end
         default: next_bus_state = BUS_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bus_state <= BUS_IDLE;
         addr_q    <= '0;
      end else begin
         bus_state <= next_bus_state;
         if (accept && hreadyout_o) begin
            addr_q <= haddr_i[ADDR_W-1:0];
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         hrdata_o <= '0;
      end else if (bus_state == BUS_RD_WAIT) begin
         hrdata_o <= {24'h000000, rd_mux};
      end
   end

   // common control registers
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         slot_preload <= PRELOAD_RST;
         start        <= C0_RST[C0_START];
         shared_slot  <= C0_RST[C0_SHARED];
         func_clk_sel <= C0_RST[C0_FSEL_LO +: 2];
         freq_sel     <= FREQ_SEL_RST;
         irq_mask     <= '0;
      end else if (wr_en) begin
         if (addr_q == OFS_SLOT_PRELOAD) slot_preload <= wdata;
         if (addr_q == OFS_CTRL_ZERO) begin
            start        <= wdata[C0_START];
            shared_slot  <= wdata[C0_SHARED];
            func_clk_sel <= wdata[C0_FSEL_LO +: 2];
         end
         // frequency code, only two bits held
         if (addr_q == OFS_CTRL_ONE) freq_sel <= wdata[1:0];
         if (addr_q == OFS_IRQ_MASK) irq_mask <= wdata[IRQ_W-1:0];
      end
   end

   assign osc_freq_sel_o = freq_sel;
   assign start_rise     = start & ~start_prev;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         start_prev <= 1'b0;
      end else begin
         start_prev <= start;
      end
   end

   // module 0 alone or every module decides the end
   assign global_ovf = run & (shared_slot ? mod_slot_ovf[0] : (&(mod_done | mod_slot_ovf)));

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         run <= 1'b0;
      end else if (!start) begin
         run <= 1'b0;
      end else if (start_rise) begin
         run <= 1'b1;
      end else if (global_ovf) begin
         run <= 1'b0;
      end
   end

   // free divider shared by the function clock and the fsys/4 slot clock
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= div_cnt + 1'b1;
      end
   end

   assign div4_en = &div_cnt[1:0];

   always_comb begin
      func_en = 1'b1;
      unique case (func_clk_sel)
         2'h0: func_en = 1'b1;
         2'h1: func_en = div_cnt[0];
         2'h2: func_en = &div_cnt[1:0];
         2'h3: func_en = &div_cnt;
      endcase
   end

   assign func_inc = run & func_en;
   assign func_ovf = func_inc & (&func_count);

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         func_count <= '0;
      end else if (!start) begin
         func_count <= '0;
      end else if (func_inc) begin
         func_count <= func_count + 1'b1;
      end
   end

   assign sense_ovf_any = |mod_sense_ovf;

   // write one has no effect, set beats clear
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         slot_ovf_flag  <= 1'b0;
         sense_ovf_flag <= 1'b0;
         func_ovf_flag  <= 1'b0;
      end else begin
         if (global_ovf) begin
            slot_ovf_flag <= 1'b1;
         end else if (wr_en && addr_q == OFS_CTRL_ZERO && !wdata[C0_SLOT_OVF]) begin
            slot_ovf_flag <= 1'b0;
         end
         if (sense_ovf_any) begin
            sense_ovf_flag <= 1'b1;
         end else if (wr_en && addr_q == OFS_CTRL_ZERO && !wdata[C0_SENSE_OVF]) begin
            sense_ovf_flag <= 1'b0;
         end
         if (func_ovf) begin
            func_ovf_flag <= 1'b1;
         end else if (wr_en && addr_q == OFS_CTRL_ZERO && !wdata[C0_FUNC_OVF]) begin
            func_ovf_flag <= 1'b0;
         end
      end
   end

   // touch irq request on slot overflow, others on sense and function overflow
   assign irq_event[IRQ_SLOT]  = global_ovf;
   assign irq_event[IRQ_SENSE] = sense_ovf_any;
   assign irq_event[IRQ_FUNC]  = func_ovf;

   // sticky status, write one to clear, a new event wins
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_status <= '0;
      end else if (wr_en && addr_q == OFS_IRQ_STATUS) begin
         irq_status <= (irq_status & ~wdata[IRQ_W-1:0]) | irq_event;
      end else begin
         irq_status <= irq_status | irq_event;
      end
   end

   assign irq_o = |(irq_status & irq_mask);

   // per-module counters and registers
   for (genvar m = 0; m < NUM_MODULES; m++) begin : g_mod
      localparam logic [ADDR_W-1:0] MB = MOD_BASE + ADDR_W'(m) * MOD_STRIDE;
      assign mofs[m] = addr_q - MB;

      // in own-slot mode a module stops at its own overflow
      assign mod_en[m]    = run & ~(mod_done[m] & ~shared_slot);
      assign osc_run_o[m] = mod_en[m];

      always_ff @(posedge clk_i or negedge rst_b_i) begin
         if (!rst_b_i) begin
            mod_done[m] <= 1'b0;
         end else if (start_rise) begin
            mod_done[m] <= 1'b0;
         end else if (mod_slot_ovf[m] && run) begin
            mod_done[m] <= 1'b1;
         end
      end

      always_ff @(posedge clk_i or negedge rst_b_i) begin
         if (!rst_b_i) begin
            mod_refcap[m] <= '0;
            mod_ctrl0[m]  <= MOD_REG_RST;
            mod_ctrl1[m]  <= MOD_REG_RST;
         end else if (wr_en) begin
            if (mofs[m] == MOFS_REFCAP_LOW) mod_refcap[m][7:0] <= wdata;
            if (mofs[m] == MOFS_REFCAP_HIGH) mod_refcap[m][REFCAP_W-1:8] <= wdata[REFCAP_W-9:0];
            if (mofs[m] == MOFS_CTRL_ZERO) mod_ctrl0[m] <= wdata;
            if (mofs[m] == MOFS_CTRL_ONE) mod_ctrl1[m] <= wdata & MC1_MASK;
         end
      end

      assign module_ctrl_zero_o[m*REG_W +: REG_W]      = mod_ctrl0[m];
      assign module_ctrl_one_o[m*REG_W +: REG_W]       = mod_ctrl1[m];
      assign module_refcap_o[m*REFCAP_W +: REFCAP_W]   = mod_refcap[m];

      tsc_module u_module (
         .clk_i          (clk_i),
         .rst_b_i        (rst_b_i),
         .clear_i        (~start),
         .load_i         (start_rise),
         .count_en_i     (mod_en[m]),
         .preload_i      (slot_preload),
         .slot_clk_sel_i (mod_ctrl1[m][MC1_SLOT_CLK]),
         .sys_div4_en_i  (div4_en),
         .ref_osc_i      (ref_osc_i[m]),
         .sense_osc_i    (sense_osc_i[m]),
         .slot_ovf_o     (mod_slot_ovf[m]),
         .sense_ovf_o    (mod_sense_ovf[m]),
         .sense_count_o  (mod_sense[m])
      );
   end

   // read mux; unmapped words and reserved bits read zero
   always_comb begin
      rd_mux = '0;
      unique case (addr_q)
         OFS_SLOT_PRELOAD: rd_mux = slot_preload;
         OFS_CTRL_ZERO: begin
            rd_mux[C0_SLOT_OVF]       = slot_ovf_flag;
            rd_mux[C0_START]          = start;
            rd_mux[C0_SENSE_OVF]      = sense_ovf_flag;
            rd_mux[C0_FUNC_OVF]       = func_ovf_flag;
            rd_mux[C0_SHARED]         = shared_slot;
            rd_mux[C0_FSEL_LO +: 2]   = func_clk_sel;
         end
         OFS_CTRL_ONE:     rd_mux = {6'h00, freq_sel};
         OFS_FUNC_LOW:     rd_mux = func_count[7:0];
         OFS_FUNC_HIGH:    rd_mux = func_count[15:8];
         OFS_IRQ_STATUS:   rd_mux = {5'h00, irq_status};
         OFS_IRQ_MASK:     rd_mux = {5'h00, irq_mask};
         default: begin
            for (int m = 0; m < NUM_MODULES; m++) begin
               if (mofs[m] == MOFS_SENSE_LOW) rd_mux = mod_sense[m][7:0];
               if (mofs[m] == MOFS_SENSE_HIGH) rd_mux = mod_sense[m][15:8];
               if (mofs[m] == MOFS_REFCAP_LOW) rd_mux = mod_refcap[m][7:0];
               if (mofs[m] == MOFS_REFCAP_HIGH) rd_mux = {6'h00, mod_refcap[m][REFCAP_W-1:8]};
               if (mofs[m] == MOFS_CTRL_ZERO) rd_mux = mod_ctrl0[m];
               if (mofs[m] == MOFS_CTRL_ONE) rd_mux = mod_ctrl1[m];
            end
         end
      endcase
   end

endmodule : tsc_top

// ==== verif/tsc_osc_model.sv ====
// Purpose: stand-in for the touch pad oscillators of each module
// Assumes: enables come from the block's run outputs
// Notes:   lines sit low while a module is stopped
`timescale 1ns/1ps
module tsc_osc_model #(
   parameter int unsigned N    = 2,
   parameter int unsigned HALF = 5
) (
   // clock
   input  wire logic         clk_i,
   // enables and oscillators
   input  wire logic [N-1:0] run_i,
   output logic      [N-1:0] ref_o,
   output logic      [N-1:0] sense_o
);
   int unsigned cnt = 0;
   always @(posedge clk_i) begin
      cnt <= (cnt == 2 * HALF - 1) ? 0 : cnt + 1;
      ref_o <= run_i & (cnt[0] ? ~ref_o : ref_o);
      sense_o <= run_i & ((cnt % HALF == 0) ? ~sense_o : sense_o);
   end
endmodule : tsc_osc_model

// ==== verif/tsc_top_checker.sv ====
// Purpose: port-level checks of the touch slot counter control
// Assumes: hready_i follows hreadyout_o
// Notes:   start bit is tracked from observed bus writes
`timescale 1ns/1ps
module tsc_top_checker #(
   parameter int unsigned NUM_MODULES = 2
) (
   input wire logic                   clk_i,
   input wire logic                   rst_b_i,
   input wire logic                   hsel_i,
   input wire logic [31:0]            haddr_i,
   input wire logic [1:0]             htrans_i,
   input wire logic                   hwrite_i,
   input wire logic [31:0]            hwdata_i,
   input wire logic                   hready_i,
   input wire logic                   hreadyout_o,
   input wire logic                   hresp_o,
   input wire logic [31:0]            hrdata_o,
   input wire logic [NUM_MODULES-1:0] osc_run_o,
   input wire logic [1:0]             osc_freq_sel_o,
   input wire logic                   irq_o
);
   import tsc_pkg::*;
   logic tk, wr, wa0, wa1, st, w0, w1;
   assign tk = hsel_i & hready_i & htrans_i[1] & hreadyout_o;
   assign w1 = wr & wa1 & hreadyout_o;
   assign w0 = wr & wa0 & hreadyout_o;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr <= 1'b0;
         wa0 <= 1'b0;
         wa1 <= 1'b0;
         st <= 1'b0;
      end else begin
         if (hreadyout_o) begin
            wr <= tk & hwrite_i;
            wa0 <= haddr_i[11:0] == OFS_CTRL_ZERO;
            wa1 <= haddr_i[11:0] == OFS_CTRL_ONE;
         end
         if (w0) st <= hwdata_i[C0_START];
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   chk_resp_okay: assert property (hresp_o == 1'b0) else $error("bad response");
   chk_read_wait: assert property (tk && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
      else $error("read wait wrong");
   chk_write_fast: assert property (tk && hwrite_i |=> hreadyout_o) else $error("write stalled");
   chk_freq_reset: assert property ($rose(rst_b_i) |-> osc_freq_sel_o == 2'h3)
      else $error("freq reset wrong");
   chk_freq_write: assert property ($changed(osc_freq_sel_o) |-> $past(w1))
      else $error("freq changed alone");
   chk_upper_zero: assert property (hreadyout_o |-> hrdata_o[31:8] == 24'h0)
      else $error("upper read bits set");
   chk_start_runs: assert property (w0 && hwdata_i[C0_START] && !st |=> ##[0:1] osc_run_o[0])
      else $error("start did not run");
   chk_stop_idle: assert property (w0 && !hwdata_i[C0_START] |=> ##[0:1] osc_run_o == '0)
      else $error("stop left running");
   chk_run_started: assert property (osc_run_o[0] |-> st || $past(st))
      else $error("run without start");
   cover property ($rose(irq_o));
   cover property ($fell(osc_run_o[0]));
   cover property (tk && !hwrite_i);
endmodule : tsc_top_checker
bind tsc_top tsc_top_checker #(.NUM_MODULES(NUM_MODULES)) chk_u (.clk_i, .rst_b_i, .hsel_i,
   .haddr_i, .htrans_i, .hwrite_i, .hwdata_i, .hready_i, .hreadyout_o, .hresp_o, .hrdata_o,
   .osc_run_o, .osc_freq_sel_o, .irq_o);

// ==== verif/tsc_top_tb.sv ====
// Purpose: self-checking bench for the touch slot counter control
// Assumes: slot clocks taken from fsys/4, module 0 from its reference oscillator in the last run
// Notes:   run lengths allow for the free-running divider phase
`timescale 1ns/1ps
module tsc_top_tb;
   import tsc_pkg::*;
   typedef struct {logic [11:0] a; logic [7:0] d; logic [7:0] e;} tsc_row_s;
   logic        clk_i = 0, rst_b_i = 0, hsel_i = 1, hwrite_i = 0, hreadyout_o, irq_o;
   logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, q;
   logic [2:0]  hsize_i = 3'h2;
   logic [1:0]  htrans_i = 0, osc_freq_sel_o, ref_osc_i, sense_osc_i, osc_run_o;
   int          n_fail = 0, comparisons = 0;
   logic [15:0] mc0, mc1;
   logic [19:0] mrc;
   tsc_row_s    rows [8] = '{'{OFS_SLOT_PRELOAD, 8'h5a, 8'h5a}, '{OFS_CTRL_ONE, 8'hff, 8'h03},
      '{OFS_CTRL_ZERO, 8'h5f, 8'h07}, '{OFS_FUNC_LOW, 8'hff, 8'h00}, '{12'h0fc, 8'hff, 8'h00},
      '{MOD_BASE + MOFS_CTRL_ZERO, 8'ha5, 8'ha5}, '{MOD_BASE + MOFS_CTRL_ONE, 8'hff, 8'hbf},
      '{MOD_BASE + MOFS_REFCAP_HIGH, 8'hff, 8'h03}};
   always #5 clk_i = ~clk_i;
   tsc_top #(.NUM_MODULES(2)) dut_u (.clk_i, .rst_b_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
      .hsize_i, .hwdata_i, .hready_i(hreadyout_o), .hreadyout_o, .hresp_o(), .hrdata_o,
      .ref_osc_i, .sense_osc_i, .osc_run_o, .osc_freq_sel_o, .module_ctrl_zero_o(mc0),
      .module_ctrl_one_o(mc1), .module_refcap_o(mrc), .irq_o);
   tsc_osc_model #(.N(2), .HALF(5)) osc_u (.clk_i, .run_i(osc_run_o), .ref_o(ref_osc_i),
      .sense_o(sense_osc_i));
   task automatic bus(input logic [11:0] a, input logic w, input logic [7:0] d);
      int n = 0;
      htrans_i <= 2'h2;
      haddr_i <= {20'h0, a};
      hwrite_i <= w;
      do begin @(negedge clk_i); n++; end while (!hreadyout_o && n < 40);
      @(posedge clk_i);
      htrans_i <= 2'h0;
      hwdata_i <= {24'h0, d};
      do begin @(negedge clk_i); n++; end while (!hreadyout_o && n < 40);
      q = hrdata_o;
      @(posedge clk_i);
      if (n >= 40) n_fail++;
   endtask : bus
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      bus(a, 1'b1, d);
   endtask : wr
   task automatic chk_eq(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_eq
   task automatic chk_near(input string nm, input int e, input logic [31:0] g, input int t);
      comparisons++;
      if ($isunknown(g) || g + t < e || g > e + t) begin
         n_fail++;
         $display("wrong value %s expected %0d seen %0d", nm, e, g);
      end
   endtask : chk_near
   task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e);
      bus(a, 1'b0, 8'h00);
      chk_eq(nm, e, q);
   endtask : rd_chk
   task automatic irq_is(input logic e);
      @(negedge clk_i);
      chk_eq("irq", {31'h0, e}, {31'h0, irq_o});
      @(posedge clk_i);
   endtask : irq_is
   task automatic meas(input logic [7:0] p, input logic [7:0] c, input int div);
      int dur = 0, ex;
      logic [7:0] lo;
      ex = (256 - p) * 128;
      wr(OFS_SLOT_PRELOAD, p);
      wr(OFS_CTRL_ZERO, c);
      wr(OFS_CTRL_ZERO, c | 8'h20);
      while (irq_o !== 1'b1 && dur < 9000) begin @(negedge clk_i); dur++; end
      @(posedge clk_i);
      chk_near("slot time", ex, dur, 6);
      rd_chk("ctrl0", OFS_CTRL_ZERO, {24'h0, c | 8'h60});
      bus(OFS_FUNC_LOW, 1'b0, 8'h00);
      lo = q[7:0];
      bus(OFS_FUNC_HIGH, 1'b0, 8'h00);
      chk_near("function count", ex / div, {q[7:0], lo}, 8);
      rd_chk("function hold", OFS_FUNC_LOW, {24'h0, lo});
      bus(MOD_BASE + MOFS_SENSE_LOW, 1'b0, 8'h00);
      chk_near("sense count", ex / 10, q, 2);
      irq_is(1'b1);
      wr(OFS_IRQ_MASK, 8'h00);
      irq_is(1'b0);
      wr(OFS_IRQ_MASK, 8'h07);
      irq_is(1'b1);
      wr(OFS_IRQ_STATUS, 8'h07);
      irq_is(1'b0);
      wr(OFS_CTRL_ZERO, c | 8'h40);
      rd_chk("flag kept", OFS_CTRL_ZERO, {24'h0, c | 8'h40});
      rd_chk("function cleared", OFS_FUNC_LOW, 32'h0);
      rd_chk("sense cleared", MOD_BASE + MOFS_SENSE_LOW, 32'h0);
      wr(OFS_CTRL_ZERO, c);
      rd_chk("flag cleared", OFS_CTRL_ZERO, {24'h0, c});
      $display("measurement done");
   endtask : meas
   task automatic finish_test;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : finish_test
   initial begin
      repeat (3) @(posedge clk_i);
      rst_b_i <= 1'b1;
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd_chk("register", rows[i].a, {24'h0, rows[i].e});
      end
      chk_eq("module control pins", 32'h00a500bf, {mc0, mc1});
      chk_eq("refcap pins", 32'h00000300, {12'h0, mrc});
      $display("register rows done");
      rst_b_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      rst_b_i <= 1'b1;
      rd_chk("preload reset", OFS_SLOT_PRELOAD, 32'h0);
      rd_chk("freq reset", OFS_CTRL_ONE, 32'h3);
      chk_eq("freq pins", 32'h3, {30'h0, osc_freq_sel_o});
      $display("reset done");
      wr(OFS_IRQ_MASK, 8'h07);
      wr(MOD_BASE + MOFS_CTRL_ONE, 8'h80);
      wr(MOD_BASE + MOD_STRIDE + MOFS_CTRL_ONE, 8'h80);
      meas(8'hff, 8'h04, 1);
      meas(8'hfe, 8'h03, 8);
      wr(MOD_BASE + MOFS_CTRL_ONE, 8'h00);
      meas(8'hff, 8'h05, 2);
      finish_test();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      n_fail++;
      finish_test();
   end
endmodule : tsc_top_tb
